/* File: core/esr_save_restore.sv */
// Register image save/restore controller for the internal nonvolatile store
`timescale 1ns/1ns
`include "esr_map.svh"

module esr_save_restore
#(
   parameter int FIFO_DEPTH  = `ESR_FIFO_DEPTH,
   parameter int NVM_BYTES   = `ESR_NVM_BYTES,
   parameter int NVM_WR_CYC  = `ESR_NVM_WR_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        hostReq,
   input  wire logic        hostWrite,
   input  wire logic [12:0] hostAddr,
   input  wire logic [7:0]  hostWdata,
   output logic             hostAck_r,
   output logic             hostRefused_r,
   output logic      [7:0]  hostRdata_r,
   output logic             i2cAddrNak_r,
   input  wire logic        statusMonitorNvm,
   output logic             statusPin_r,
   input  wire logic        loadSelPin,
   input  wire logic [7:0]  cfgRdata,
   output logic      [15:0] cfgAddr_r,
   output logic      [7:0]  cfgWdata_r,
   output logic             cfgWrite_r,
   output logic             cfgCommit_r,
   output logic             loadDefaults_r
);
   import esr_pkg::*;

   localparam int PW = $clog2(NVM_BYTES) + 1;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   esr_state_t state_r;
   esr_phase_t phase_r;
   logic [7:0] bufMem_r [0:`ESR_BUF_BYTES-1];
   logic [4:0] bufIdx_r;
   logic [6:0] remain_r;
   logic [7:0] addrLo_r;
   logic [PW-1:0] nvmPtr_r;
   logic       endHit_r;
   logic       busy_r;
   logic       fault_r;
   logic       writeEn_r;
   logic       saveReq_r;
   logic       loadSelMeta_r;
   logic       loadSelSync_r;
   logic       bootPend_r;
   logic [1:0] bootCnt_r;

   logic       hostWrOk;
   logic       hostBlocked;
   logic       startSave;
   logic       startLoad;
   logic       bootStart;
   logic       saveFinish;
   logic       faultEvt;
   logic [7:0] bufByte;
   logic       bufInRange;
   logic       opLegal;
   logic       fifoInValid;
   logic       fifoInReady;
   logic [7:0] fifoInData;
   logic       fifoAdvance;
   logic       fifoOutValid;
   logic       fifoOutReady;
   logic [7:0] fifoOutData;
   logic       storeReady;
   logic       storeWrite;
   logic       nvmFull;
   logic [7:0] nvmRdata;

   // Defaults: four full groups of 128 plus one of 50, then commit and end
   function automatic logic [7:0] bufDefault(input int idx);
      int grp;
      int base;
      grp  = idx / 3;
      base = grp * `ESR_GROUP_MAX;
      if (idx < 3 * `ESR_DEF_GROUPS) begin
         case (idx % 3)
            0:       bufDefault = (grp == `ESR_DEF_GROUPS - 1) ? `ESR_DEF_LAST_CNT : `ESR_DEF_FULL_CNT;
            1:       bufDefault = 8'(base);
            default: bufDefault = 8'(base >> 8);
         endcase
      end else if (idx == 3 * `ESR_DEF_GROUPS) begin
         bufDefault = `ESR_OP_COMMIT;
      end else if (idx == 3 * `ESR_DEF_GROUPS + 1) begin
         bufDefault = `ESR_OP_END;
      end else begin
         bufDefault = 8'h00;
      end
   endfunction

   // ----------------------------------------------------------------
   // Load-select pin synchroniser and boot decision
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         loadSelMeta_r <= 1'b0;
         loadSelSync_r <= 1'b0;
      end else begin
         loadSelMeta_r <= loadSelPin;
         loadSelSync_r <= loadSelMeta_r;
      end
   end

   // Pin is only trusted once it has crossed both flops after release
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         bootPend_r     <= 1'b1;
         bootCnt_r      <= 2'h0;
         loadDefaults_r <= 1'b0;
      end else begin
         loadDefaults_r <= 1'b0;
         if (bootPend_r) begin
            if (bootCnt_r == `ESR_SYNC_WAIT) begin
               bootPend_r     <= 1'b0;
               loadDefaults_r <= !loadSelSync_r;
            end else begin
               bootCnt_r <= bootCnt_r + 2'h1;
            end
         end
      end
   end

   assign bootStart = bootPend_r && (bootCnt_r == `ESR_SYNC_WAIT) && loadSelSync_r;

   // ----------------------------------------------------------------
   // Serial-port register access
   // ----------------------------------------------------------------
   assign hostBlocked = busy_r && !(!hostWrite && hostAddr == `ESR_OFS_BUSY);
   assign hostWrOk    = hostReq && hostWrite && !busy_r;
   assign startSave   = hostWrOk && hostAddr == `ESR_OFS_COMMIT && hostWdata[`ESR_BIT_COMMIT]
                        && writeEn_r && saveReq_r;
   assign startLoad   = bootStart
                        || (hostWrOk && hostAddr == `ESR_OFS_WE_LOAD && hostWdata[`ESR_BIT_SOFT_LOAD]
                            && !loadSelSync_r)
                        || (hostWrOk && hostAddr == `ESR_OFS_SOFT_RESET && hostWdata[`ESR_BIT_SOFT_RESET]
                            && loadSelSync_r);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hostAck_r     <= 1'b0;
         hostRefused_r <= 1'b0;
         hostRdata_r   <= 8'h00;
      end else begin
         hostAck_r     <= hostReq;
         hostRefused_r <= hostReq && hostBlocked;
         hostRdata_r   <= 8'h00;
         if (hostReq && !hostWrite && !hostBlocked) begin
            if (hostAddr == `ESR_OFS_BUSY) begin
               hostRdata_r[`ESR_BIT_BUSY] <= busy_r;
            end else if (hostAddr == `ESR_OFS_FAULT) begin
               hostRdata_r[`ESR_BIT_FAULT] <= fault_r;
            end else if (hostAddr == `ESR_OFS_WE_LOAD) begin
               hostRdata_r[`ESR_BIT_WRITE_EN] <= writeEn_r;
            end else if (hostAddr == `ESR_OFS_SAVE_REQ) begin
               hostRdata_r[`ESR_BIT_SAVE_REQ] <= saveReq_r;
            end else if (hostAddr >= `ESR_OFS_BUF_BASE
                         && hostAddr < `ESR_OFS_BUF_BASE + 13'(`ESR_BUF_BYTES)) begin
               hostRdata_r <= bufMem_r[5'(hostAddr - `ESR_OFS_BUF_BASE)];
            end
         end
      end
   end

   // No address reaches the store: only the save sequence writes it
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `ESR_BUF_BYTES; i++) begin
            bufMem_r[i] <= bufDefault(i);
         end
      end else if (hostWrOk && hostAddr >= `ESR_OFS_BUF_BASE
                   && hostAddr < `ESR_OFS_BUF_BASE + 13'(`ESR_BUF_BYTES)) begin
         bufMem_r[5'(hostAddr - `ESR_OFS_BUF_BASE)] <= hostWdata;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         writeEn_r <= `ESR_RST_WRITE_EN;
      end else if (hostWrOk && hostAddr == `ESR_OFS_WE_LOAD) begin
         writeEn_r <= hostWdata[`ESR_BIT_WRITE_EN];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         saveReq_r <= `ESR_RST_SAVE_REQ;
      end else if (saveFinish) begin
         saveReq_r <= 1'b0;
      end else if (hostWrOk && hostAddr == `ESR_OFS_SAVE_REQ) begin
         saveReq_r <= hostWdata[`ESR_BIT_SAVE_REQ];
      end
   end

   // ----------------------------------------------------------------
   // Save path: buffer segment and register values into the FIFO
   // ----------------------------------------------------------------
   assign bufInRange = (bufIdx_r < 5'(`ESR_BUF_BYTES));
   assign bufByte    = bufInRange ? bufMem_r[bufIdx_r] : 8'h00;
   assign opLegal    = !bufByte[7] || bufByte == `ESR_OP_COMMIT
                       || bufByte == `ESR_OP_PSEUDO_END || bufByte == `ESR_OP_END;

   always_comb begin
      fifoInValid = 1'b0;
      fifoInData  = bufByte;
      unique case (state_r)
         ST_SV_OP:   fifoInValid = bufInRange && opLegal;
         ST_SV_ALO:  fifoInValid = 1'b1;
         ST_SV_AHI:  fifoInValid = 1'b1;
         ST_SV_DATA: begin
            fifoInValid = 1'b1;
            fifoInData  = cfgRdata;
         end
         default:    fifoInValid = 1'b0;
      endcase
   end

   assign fifoAdvance = fifoInValid && fifoInReady;

   esr_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .reset    (reset),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // A full store drops the remaining bytes and flags the save as failed
   assign nvmFull      = (nvmPtr_r >= PW'(NVM_BYTES));
   assign storeWrite   = fifoOutValid && !nvmFull;
   assign fifoOutReady = nvmFull || storeReady;

   esr_nvm_store #(
      .BYTES     (NVM_BYTES),
      .WR_CYCLES (NVM_WR_CYC)
   ) u_store (
      .core_clk (core_clk),
      .reset    (reset),
      .wrValid  (storeWrite),
      .wrReady  (storeReady),
      .wrAddr   (nvmPtr_r[PW-2:0]),
      .wrData   (fifoOutData),
      .rdAddr   (nvmPtr_r[PW-2:0]),
      .rdData   (nvmRdata)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign saveFinish = (state_r == ST_SV_DRAIN) && !fifoOutValid && storeReady;
   assign faultEvt   = (fifoOutValid && nvmFull)
                       || (state_r == ST_SV_OP && (!bufInRange || !opLegal))
                       || (state_r == ST_RS_RD && nvmFull)
                       || (state_r == ST_RS_USE && phase_r == PH_OP && nvmRdata[7]
                           && nvmRdata != `ESR_OP_COMMIT && nvmRdata != `ESR_OP_PSEUDO_END
                           && nvmRdata != `ESR_OP_END);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r     <= ST_IDLE;
         phase_r     <= PH_OP;
         bufIdx_r    <= 5'h00;
         remain_r    <= 7'h00;
         addrLo_r    <= 8'h00;
         cfgAddr_r   <= 16'h0000;
         cfgWdata_r  <= 8'h00;
         cfgWrite_r  <= 1'b0;
         cfgCommit_r <= 1'b0;
      end else begin
         cfgWrite_r  <= 1'b0;
         cfgCommit_r <= hostWrOk && hostAddr == `ESR_OFS_COMMIT && hostWdata[`ESR_BIT_COMMIT] && !startSave;
         unique case (state_r)
            ST_IDLE: begin
               bufIdx_r <= 5'h00;
               phase_r  <= PH_OP;
               if (startSave) begin
                  state_r <= ST_SV_OP;
               end else if (startLoad) begin
                  state_r <= ST_RS_RD;
               end
            end
            ST_SV_OP: begin
               if (!bufInRange || !opLegal) begin
                  state_r <= ST_SV_DRAIN;
               end else if (fifoAdvance) begin
                  bufIdx_r <= bufIdx_r + 5'h01;
                  if (!bufByte[7]) begin
                     remain_r <= bufByte[6:0];
                     state_r  <= ST_SV_ALO;
                  end else if (bufByte != `ESR_OP_COMMIT) begin
                     state_r <= ST_SV_DRAIN;
                  end
               end
            end
            ST_SV_ALO: begin
               if (fifoAdvance) begin
                  addrLo_r <= bufByte;
                  bufIdx_r <= bufIdx_r + 5'h01;
                  state_r  <= ST_SV_AHI;
               end
            end
            ST_SV_AHI: begin
               if (fifoAdvance) begin
                  cfgAddr_r <= {bufByte, addrLo_r};
                  bufIdx_r  <= bufIdx_r + 5'h01;
                  state_r   <= ST_SV_DATA;
               end
            end
            ST_SV_DATA: begin
               if (fifoAdvance) begin
                  cfgAddr_r <= cfgAddr_r + 16'h0001;
                  remain_r  <= remain_r - 7'h01;
                  if (remain_r == 7'h00) begin
                     state_r <= ST_SV_OP;
                  end
               end
            end
            ST_SV_DRAIN: begin
               if (saveFinish) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_RS_RD: begin
               state_r <= nvmFull ? ST_IDLE : ST_RS_USE;
            end
            ST_RS_USE: begin
               state_r <= ST_RS_RD;
               unique case (phase_r)
                  PH_OP: begin
                     if (!nvmRdata[7]) begin
                        remain_r <= nvmRdata[6:0];
                        phase_r  <= PH_ALO;
                     end else if (nvmRdata == `ESR_OP_COMMIT) begin
                        cfgCommit_r <= 1'b1;
                     end else if (nvmRdata != `ESR_OP_PSEUDO_END) begin
                        state_r <= ST_IDLE;
                     end
                  end
                  PH_ALO: begin
                     addrLo_r <= nvmRdata;
                     phase_r  <= PH_AHI;
                  end
                  PH_AHI: begin
                     // One below the start: each data write pre-increments
                     cfgAddr_r <= {nvmRdata, addrLo_r} - 16'h0001;
                     phase_r   <= PH_DATA;
                  end
                  PH_DATA: begin
                     cfgAddr_r  <= cfgAddr_r + 16'h0001;
                     cfgWdata_r <= nvmRdata;
                     cfgWrite_r <= 1'b1;
                     remain_r   <= remain_r - 7'h01;
                     if (remain_r == 7'h00) begin
                        phase_r <= PH_OP;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   // Store pointer: kept across a pause, rewound by an end or a restore
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nvmPtr_r <= '0;
      end else if (state_r == ST_IDLE && startLoad && !startSave) begin
         nvmPtr_r <= '0;
      end else if (storeWrite && storeReady) begin
         nvmPtr_r <= nvmPtr_r + 1'b1;
      end else if (state_r == ST_RS_USE) begin
         nvmPtr_r <= nvmPtr_r + 1'b1;
      end else if (saveFinish && endHit_r) begin
         nvmPtr_r <= '0;
      end
   end

   // In a save only an end opcode rewinds the store; a pause keeps the pointer for the next save
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         endHit_r <= 1'b0;
      end else if (state_r == ST_IDLE) begin
         endHit_r <= 1'b0;
      end else if (state_r == ST_SV_OP && fifoAdvance && bufByte == `ESR_OP_END) begin
         endHit_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Busy, fault and status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
      end else if (state_r == ST_IDLE) begin
         busy_r <= startSave || startLoad;
      end else if (saveFinish
                   || (state_r == ST_RS_RD && nvmFull)
                   || (state_r == ST_RS_USE && phase_r == PH_OP && nvmRdata[7]
                       && nvmRdata != `ESR_OP_COMMIT && nvmRdata != `ESR_OP_PSEUDO_END)) begin
         busy_r <= 1'b0;
      end
   end

   // A fault seen in the start cycle still wins over the clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fault_r <= 1'b0;
      end else if (faultEvt) begin
         fault_r <= 1'b1;
      end else if (state_r == ST_IDLE && (startSave || startLoad)) begin
         fault_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         i2cAddrNak_r <= 1'b0;
         statusPin_r  <= 1'b0;
      end else begin
         i2cAddrNak_r <= busy_r;
         statusPin_r  <= statusMonitorNvm && busy_r;
      end
   end
endmodule

/* File: common/esr_map.svh */
// Register offsets, field positions, reset values and limits of the save/restore controller
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH

`define ESR_OFS_SOFT_RESET   13'h000
`define ESR_OFS_COMMIT       13'h232
`define ESR_OFS_BUF_BASE     13'ha00
`define ESR_OFS_BUSY         13'hb00
`define ESR_OFS_FAULT        13'hb01
`define ESR_OFS_WE_LOAD      13'hb02
`define ESR_OFS_SAVE_REQ     13'hb03

`define ESR_BIT_SOFT_RESET   5
`define ESR_BIT_COMMIT       0
`define ESR_BIT_WRITE_EN     0
`define ESR_BIT_SOFT_LOAD    1
`define ESR_BIT_SAVE_REQ     0
`define ESR_BIT_BUSY         0
`define ESR_BIT_FAULT        0

`define ESR_RST_WRITE_EN     1'b0
`define ESR_RST_SAVE_REQ     1'b0

`define ESR_NVM_BYTES        512
`define ESR_BUF_BYTES        23
`define ESR_GROUP_MAX        128
`define ESR_FIFO_DEPTH       16
`define ESR_NVM_WR_CYCLES    8
`define ESR_SYNC_WAIT        2'h3

`define ESR_OP_COMMIT        8'h80
`define ESR_OP_PSEUDO_END    8'hfe
`define ESR_OP_END           8'hff
`define ESR_ERASED           8'hff

`define ESR_DEF_GROUPS       5
`define ESR_DEF_FULL_CNT     8'h7f
`define ESR_DEF_LAST_CNT     8'h31

`endif

/* File: common/esr_pkg.sv */
// Types shared by the save/restore controller
package esr_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_SV_OP,
      ST_SV_ALO,
      ST_SV_AHI,
      ST_SV_DATA,
      ST_SV_DRAIN,
      ST_RS_RD,
      ST_RS_USE
   } esr_state_t;

   typedef enum logic [1:0] {
      PH_OP,
      PH_ALO,
      PH_AHI,
      PH_DATA
   } esr_phase_t;

endpackage

/* File: core/esr_fifo.sv */
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module esr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign inReady  = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem[rdPtr_r];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: core/esr_nvm_store.sv */
// Nonvolatile byte store model: slow writes, one-cycle reads, erased bytes read as all ones
`timescale 1ns/1ns
`include "esr_map.svh"
module esr_nvm_store #(
   parameter int BYTES     = 512,
   parameter int WR_CYCLES = 8
) (
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     wrValid,
   output logic                          wrReady,
   input  wire logic [$clog2(BYTES)-1:0] wrAddr,
   input  wire logic [7:0]               wrData,
   input  wire logic [$clog2(BYTES)-1:0] rdAddr,
   output logic      [7:0]               rdData
);
   logic [7:0]  mem [0:BYTES-1];
   // Written flags survive reset: the store is nonvolatile and a boot restore must still see the image
   logic [BYTES-1:0] written_r = '0;
   logic [15:0] wait_r;

   assign wrReady = (wait_r == '0);

   always_ff @(posedge core_clk) begin
      if (wrValid && wrReady) begin
         mem[wrAddr]       <= wrData;
         written_r[wrAddr] <= 1'b1;
      end
      rdData <= written_r[rdAddr] ? mem[rdAddr] : `ESR_ERASED;
   end

   // Each write keeps the store busy, so the feeding buffer really fills
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wait_r <= '0;
      end else if (wrValid && wrReady) begin
         wait_r <= 16'(WR_CYCLES);
      end else if (wait_r != '0) begin
         wait_r <= wait_r - 16'h0001;
      end
   end
endmodule

/* File: verification/esr_monitor.sv */
// Concurrent checks on the save/restore controller ports
`timescale 1ns/1ns
module esr_monitor (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        hostReq,
   input wire logic        hostWrite,
   input wire logic [12:0] hostAddr,
   input wire logic        hostAck_r,
   input wire logic        hostRefused_r,
   input wire logic [7:0]  hostRdata_r,
   input wire logic        i2cAddrNak_r,
   input wire logic        statusMonitorNvm,
   input wire logic        statusPin_r,
   input wire logic        cfgWrite_r,
   input wire logic        cfgCommit_r,
   input wire logic        loadDefaults_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Busy readback stays open during transfers
   // ----------------------------------------
   sequence busyRead;
      hostReq && !hostWrite && hostAddr == 13'hb00;
   endsequence
   sequence busyAnswer;
      hostAck_r && !hostRefused_r && hostRdata_r[0] == i2cAddrNak_r;
   endsequence
   answer_follows_a : assert property (hostReq |=> hostAck_r) else $error("request not answered");
   answer_has_cause_a : assert property (hostAck_r |-> $past(hostReq)) else $error("stray answer");
   busy_readable_a : assert property (busyRead |=> busyAnswer) else $error("busy readback wrong");
   refused_empty_a : assert property (hostRefused_r |-> hostAck_r && hostRdata_r == 8'h00)
      else $error("refused access carried data");
   status_pin_a : assert property (statusPin_r == ($past(statusMonitorNvm) && i2cAddrNak_r))
      else $error("status pin does not follow busy");
   restore_busy_a : assert property (cfgWrite_r |-> i2cAddrNak_r) else $error("register write while idle");
   commit_pulse_a : assert property (cfgCommit_r |=> !cfgCommit_r) else $error("commit not a pulse");
   defaults_idle_a : assert property (loadDefaults_r |-> !i2cAddrNak_r ##1 !loadDefaults_r)
      else $error("defaults load during transfer");
endmodule
bind esr_save_restore esr_monitor i_mon (.*);

/* File: verification/esr_reg_bank.sv */
// Chip register bank model: known read pattern, tallies restored writes and commits
`timescale 1ns/1ns
module esr_reg_bank (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [15:0] cfgAddr,
   input  wire logic [7:0]  cfgWdata,
   input  wire logic        cfgWrite,
   input  wire logic        cfgCommit,
   output logic      [7:0]  cfgRdata,
   output int               nGood,
   output int               nCommits,
   output logic      [15:0] lastAddr
);
   // Pattern tied to the address so a misplaced byte shows up on restore
   // Calibrate-now bit stays set in the image, as a host preparing a save leaves it
   function automatic logic [7:0] img(input logic [15:0] a);
      return (a[7:0] ^ 8'h3c) | {7'h00, a == 16'h0018};
   endfunction
   assign cfgRdata = img(cfgAddr);
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nGood <= 0;
         nCommits <= 0;
         lastAddr <= 16'h0000;
      end else begin
         if (cfgWrite && cfgWdata == img(cfgAddr)) begin
            nGood <= nGood + 1;
            lastAddr <= cfgAddr;
         end
         if (cfgCommit) nCommits <= nCommits + 1;
      end
   end
endmodule

/* File: verification/esr_save_restore_bench.sv */
// Self-checking bench: save an image, then restore it by software load
`timescale 1ns/1ns
module esr_save_restore_bench;
   logic        core_clk = 0, reset = 1, hostReq = 0, hostWrite = 0, statusMonitorNvm = 1, loadSelPin = 0;
   logic [12:0] hostAddr = 13'h0000;
   logic [7:0]  hostWdata = 8'h00, cfgRdata, hostRdata_r, cfgWdata_r, rd, lo;
   logic [15:0] cfgAddr_r, lastAddr;
   logic        hostAck_r, hostRefused_r, i2cAddrNak_r, statusPin_r, cfgWrite_r, cfgCommit_r, loadDefaults_r, refd;
   int          fail_count = 0, n_checks = 0, seed = 41806, nGood, nCommits, i;
   always #5 core_clk = ~core_clk;
   esr_save_restore #(.NVM_WR_CYC(1)) i_dut (.*);
   esr_reg_bank i_bank (.core_clk(core_clk), .reset(reset), .cfgAddr(cfgAddr_r), .cfgWdata(cfgWdata_r),
      .cfgWrite(cfgWrite_r), .cfgCommit(cfgCommit_r), .cfgRdata(cfgRdata), .nGood(nGood),
      .nCommits(nCommits), .lastAddr(lastAddr));
   function automatic logic [7:0] lastOf(input logic [7:0] start, input logic [7:0] cnt);
      return start + cnt;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic acc(input logic wr, input logic [12:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      {hostReq, hostWrite, hostAddr, hostWdata} = {1'b1, wr, a, d};
      statusMonitorNvm = $random(seed);
      @(posedge core_clk) #1;
      hostReq = 0;
      rd = hostRdata_r;
      refd = hostRefused_r;
   endtask
   task automatic waitIdle;
      int k;
      for (k = 0; k < 300; k++) begin
         acc(0, 13'hb00, 8'h00);
         if (rd === 8'h00) break;
      end
      if (k == 300) begin
         fail_count++;
         tally_and_finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1 reset = 0;
      i = 0;
      while (loadDefaults_r !== 1'b1 && i < 20) begin
         @(posedge core_clk) #1;
         i++;
      end
      chk("loadDefaults", 8'h01, {7'h00, loadDefaults_r});
      acc(0, 13'hb03, 8'h00); chk("saveReqReset", 8'h00, rd);
      acc(0, 13'hb04, 8'h00); chk("unmapped", 8'h00, rd);
      for (i = 5; i < 23; i++) begin
         lo = $random(seed);
         acc(1, 13'ha00 + 13'(i), lo);
         acc(0, 13'ha00 + 13'(i), 8'h00); chk("buffer", lo, rd);
      end
      lo = $random(seed) & 8'h7f;
      // One group of three registers, commit, end
      acc(1, 13'ha00, 8'h02); acc(1, 13'ha01, lo); acc(1, 13'ha02, 8'h00);
      acc(1, 13'ha03, 8'h80); acc(1, 13'ha04, 8'hff);
      acc(1, 13'hb02, 8'h01); acc(1, 13'hb03, 8'h01); acc(1, 13'h232, 8'h01);
      acc(1, 13'hb03, 8'h00); chk("refused", 8'h01, {7'h00, refd});
      acc(0, 13'hb00, 8'h00); chk("busy", 8'h01, rd);
      waitIdle;
      acc(0, 13'hb03, 8'h00); chk("saveReqClear", 8'h00, rd);
      acc(0, 13'hb01, 8'h00); chk("fault", 8'h00, rd);
      acc(1, 13'hb02, 8'h02);
      waitIdle;
      chk("restoreWrites", 8'h03, nGood[7:0]);
      chk("lastAddr", lastOf(lo, 8'h02), lastAddr[7:0]);
      chk("commits", 8'h01, nCommits[7:0]);
      // Pin high: soft reset bit restores the same image again
      loadSelPin = 1;
      acc(0, 13'hb01, 8'h00); chk("faultRestore", 8'h00, rd);
      acc(1, 13'h000, 8'h20);
      waitIdle;
      chk("softResetWrites", 8'h06, nGood[7:0]);
      chk("softResetCommits", 8'h02, nCommits[7:0]);
      // Reset pulse with the pin high: boot restore from the retained store
      @(posedge core_clk) #1 reset = 1;
      @(posedge core_clk) #1 reset = 0;
      repeat (6) @(posedge core_clk);
      waitIdle;
      chk("bootWrites", 8'h03, nGood[7:0]);
      chk("bootLast", lastOf(lo, 8'h02), lastAddr[7:0]);
      chk("bootCommits", 8'h01, nCommits[7:0]);
      tally_and_finish;
   end
endmodule
